// file: rtl/regulator_settings_map.vh
// register offsets, field positions, reset values and timing for the
// regulator settings bank; included by the settings register bank only, not by the delay channel
`ifndef REGULATOR_SETTINGS_MAP_VH
`define REGULATOR_SETTINGS_MAP_VH
// printed offsets are not all multiples of four: index, byte = 4 * index
`define IDX_LDO_THREE    8'h03
`define IDX_LDO_FOUR     8'h04
`define IDX_LDO_FIVE     8'h05
`define IDX_BUCK_FIRST   8'h06
`define IDX_BUCK_SECOND  8'h07
`define IDX_CONTROL      8'h08
`define RST_LDO_THREE    8'h6c
`define RST_LDO_FOUR     8'h9e
`define RST_LDO_FIVE     8'hb1
`define RST_BUCK_FIRST   8'h09
`define RST_BUCK_SECOND  8'h07
`define RST_CONTROL      8'h00
// field positions
`define DELAY_HI         7
`define DELAY_LO         5
`define VCODE_HI         4
`define VCODE_LO         0
`define MODE_BIT         5
`define SECOND_MASK      8'h3f
`define VSEL_BIT         0
// delay step 128 us, clock 100 MHz (10 ns)
`define STEP_US          128
`define CLK_NS           10
`define STEP_CYCLES      ((`STEP_US * 1000) / `CLK_NS)
// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// file: rtl/startup_delay.v
// one start-up delay channel: counts (code + 1) steps after a trigger
// assumes trig is a one-cycle pulse on aclk, code stable from software
`timescale 1ns/1ps
module startup_delay #(
  parameter STEP_CYCLES = 12800,
  parameter CW          = 14
)
(
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // control
  input  wire         trig,
  input  wire         hold,
  input  wire [2:0]   code,
  // result
  output reg          started
);
  reg [CW-1:0] tick_r;
  reg [3:0]    steps_r;
  reg          run_r;

  always @(posedge aclk)
  begin
    if (!aresetn || hold)
    begin
      tick_r  <= {CW{1'b0}};
      steps_r <= 4'h0;
      run_r   <= 1'b0;
      started <= 1'b0;
    end
    else if (trig)
    begin
      // code latched at the edge; later writes do not move this start
      tick_r  <= {CW{1'b0}};
      steps_r <= {1'b0, code} + 4'h1;
      run_r   <= 1'b1;
      started <= 1'b0;
    end
    else if (run_r)
    begin
      if (tick_r == STEP_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
      begin
        tick_r <= {CW{1'b0}};
        if (steps_r == 4'h1)
        begin
          run_r   <= 1'b0;
          started <= 1'b1;
        end
        steps_r <= steps_r - 4'h1;
      end
      else
        tick_r <= tick_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // startup_delay

// file: rtl/regulator_setting_registers.v
// regulator settings bank: voltage codes, start-up delays, buck mode
// assumes an axi4-lite master on aclk and an asynchronous enable pin
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "regulator_settings_map.vh"
module regulator_setting_registers #(
  parameter STEP_CYCLES = `STEP_CYCLES,
  parameter CW          = 14
)
(
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // axi4-lite write address
  input  wire [31:0]  s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output wire         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output wire         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  // axi4-lite read address
  input  wire [31:0]  s_axi_araddr,
  input  wire         s_axi_arvalid,
  output wire         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  // enable pin, asynchronous
  input  wire         hardware_enable_pin,
  // regulator controls
  output reg  [3:0]   rail_started,
  output reg  [8:0]   ldo3_millivolt_cs,
  output reg  [8:0]   ldo4_millivolt_cs,
  output reg  [8:0]   ldo5_millivolt_cs,
  output reg  [4:0]   buck_target_code,
  output reg          buck_forced_pwm
);

////////////////////////////////////////////////////////////////////////
// voltage tables, outputs in units of 10 mV

  function [8:0] ldo_high_volts;
    input [4:0] c;
    begin
      case (c)
        5'h0b: ldo_high_volts = 9'd175;
        5'h0c: ldo_high_volts = 9'd180;
        5'h0d: ldo_high_volts = 9'd185;
        5'h0e: ldo_high_volts = 9'd190;
        5'h0f: ldo_high_volts = 9'd200;
        5'h10: ldo_high_volts = 9'd210;
        5'h11: ldo_high_volts = 9'd220;
        5'h12: ldo_high_volts = 9'd230;
        5'h13: ldo_high_volts = 9'd240;
        5'h14: ldo_high_volts = 9'd250;
        5'h15: ldo_high_volts = 9'd260;
        5'h16: ldo_high_volts = 9'd265;
        5'h17: ldo_high_volts = 9'd270;
        5'h18: ldo_high_volts = 9'd275;
        5'h19: ldo_high_volts = 9'd280;
        5'h1a: ldo_high_volts = 9'd285;
        5'h1b: ldo_high_volts = 9'd290;
        5'h1c: ldo_high_volts = 9'd295;
        5'h1d: ldo_high_volts = 9'd300;
        5'h1e: ldo_high_volts = 9'd310;
        5'h1f: ldo_high_volts = 9'd330;
        default: ldo_high_volts = 9'd170;
      endcase
    end
  endfunction

  function [8:0] ldo_low_volts;
    input [4:0] c;
    begin
      case (c)
        5'h06: ldo_low_volts = 9'd125;
        5'h07: ldo_low_volts = 9'd130;
        5'h08: ldo_low_volts = 9'd135;
        5'h09: ldo_low_volts = 9'd140;
        5'h0a: ldo_low_volts = 9'd145;
        5'h0b: ldo_low_volts = 9'd150;
        5'h0c: ldo_low_volts = 9'd155;
        5'h0d: ldo_low_volts = 9'd160;
        5'h0e: ldo_low_volts = 9'd165;
        5'h0f: ldo_low_volts = 9'd170;
        5'h10: ldo_low_volts = 9'd175;
        5'h11: ldo_low_volts = 9'd180;
        5'h12: ldo_low_volts = 9'd185;
        5'h13: ldo_low_volts = 9'd190;
        5'h14: ldo_low_volts = 9'd200;
        5'h15: ldo_low_volts = 9'd210;
        5'h16: ldo_low_volts = 9'd220;
        5'h17: ldo_low_volts = 9'd230;
        5'h18: ldo_low_volts = 9'd240;
        5'h19: ldo_low_volts = 9'd250;
        5'h1a: ldo_low_volts = 9'd260;
        5'h1b: ldo_low_volts = 9'd265;
        5'h1c: ldo_low_volts = 9'd270;
        5'h1d: ldo_low_volts = 9'd275;
        5'h1e: ldo_low_volts = 9'd280;
        5'h1f: ldo_low_volts = 9'd285;
        default: ldo_low_volts = 9'd120;
      endcase
    end
  endfunction

  // word index from a byte address; low two bits ignored
  function [7:0] word_index;
    input [31:0] a;
    begin
      word_index = a[9:2];
    end
  endfunction

  function index_mapped;
    input [7:0] i;
    begin
      index_mapped = (i >= `IDX_LDO_THREE) && (i <= `IDX_CONTROL);
    end
  endfunction

////////////////////////////////////////////////////////////////////////
// registers

  reg  [7:0]  ldo_three_settings_r;
  reg  [7:0]  ldo_four_settings_r;
  reg  [7:0]  ldo_five_settings_r;
  reg  [7:0]  buck_settings_first_r;
  reg  [7:0]  buck_settings_second_r;
  reg  [7:0]  control_r;
  reg  [31:0] awaddr_r;
  reg         aw_held_r;
  reg  [7:0]  wdata_r;
  reg         w_held_r;
  reg         w_lane_r;

  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take  = s_axi_wvalid && s_axi_wready;
  wire        do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [7:0]  widx    = word_index(awaddr_r);
  wire        wr_ok   = do_write && w_lane_r;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // address and data are taken in either order, then joined
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_r  <= 32'h0000_0000;
      aw_held_r <= 1'b0;
      wdata_r   <= 8'h00;
      w_held_r  <= 1'b0;
      w_lane_r  <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        awaddr_r  <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end
      else if (do_write)
        aw_held_r <= 1'b0;
      if (w_take)
      begin
        wdata_r  <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
        w_held_r <= 1'b1;
      end
      else if (do_write)
        w_held_r <= 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ldo_three_settings_r   <= `RST_LDO_THREE;
      ldo_four_settings_r    <= `RST_LDO_FOUR;
      ldo_five_settings_r    <= `RST_LDO_FIVE;
      buck_settings_first_r  <= `RST_BUCK_FIRST;
      buck_settings_second_r <= `RST_BUCK_SECOND;
      control_r              <= `RST_CONTROL;
    end
    else if (wr_ok)
    begin
      if (widx == `IDX_LDO_THREE)
        ldo_three_settings_r <= wdata_r;
      else if (widx == `IDX_LDO_FOUR)
        ldo_four_settings_r <= wdata_r;
      else if (widx == `IDX_LDO_FIVE)
        ldo_five_settings_r <= wdata_r;
      else if (widx == `IDX_BUCK_FIRST)
        buck_settings_first_r <= wdata_r;
      else if (widx == `IDX_BUCK_SECOND)
        buck_settings_second_r <= wdata_r & `SECOND_MASK;
      else if (widx == `IDX_CONTROL)
        control_r <= {7'h00, wdata_r[`VSEL_BIT]};
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= index_mapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  reg  [7:0] rbyte;
  wire [7:0] ridx = word_index(s_axi_araddr);

  always @*
  begin
    rbyte = 8'h00;
    if (ridx == `IDX_LDO_THREE)
      rbyte = ldo_three_settings_r;
    else if (ridx == `IDX_LDO_FOUR)
      rbyte = ldo_four_settings_r;
    else if (ridx == `IDX_LDO_FIVE)
      rbyte = ldo_five_settings_r;
    else if (ridx == `IDX_BUCK_FIRST)
      rbyte = buck_settings_first_r;
    else if (ridx == `IDX_BUCK_SECOND)
      rbyte = buck_settings_second_r & `SECOND_MASK;
    else if (ridx == `IDX_CONTROL)
      rbyte = {3'h0, rail_started, control_r[`VSEL_BIT]};
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rbyte};
      s_axi_rresp  <= index_mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

////////////////////////////////////////////////////////////////////////
// enable pin synchroniser and start-up delays

  reg        en_meta_r;
  reg        en_sync_r;
  reg        en_prev_r;
  wire       en_rise = en_sync_r && !en_prev_r;
  wire [3:0] started_w;
  wire [11:0] delay_codes = {
    buck_settings_first_r[`DELAY_HI:`DELAY_LO],
    ldo_five_settings_r[`DELAY_HI:`DELAY_LO],
    ldo_four_settings_r[`DELAY_HI:`DELAY_LO],
    ldo_three_settings_r[`DELAY_HI:`DELAY_LO]};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
      en_prev_r <= 1'b0;
    end
    else
    begin
      en_meta_r <= hardware_enable_pin;
      en_sync_r <= en_meta_r;
      en_prev_r <= en_sync_r;
    end
  end

  // pin low drops every rail; the delays run only from a rising edge
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : rail
      startup_delay #(
        .STEP_CYCLES (STEP_CYCLES),
        .CW          (CW)
      ) u_delay (
        .aclk    (aclk),
        .aresetn (aresetn),
        .trig    (en_rise),
        .hold    (!en_sync_r),
        .code    (delay_codes[3*g+2:3*g]),
        .started (started_w[g])
      );
    end
  endgenerate

////////////////////////////////////////////////////////////////////////
// decoded outputs

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rail_started      <= 4'h0;
      ldo3_millivolt_cs <= 9'd0;
      ldo4_millivolt_cs <= 9'd0;
      ldo5_millivolt_cs <= 9'd0;
      buck_target_code  <= 5'h00;
      buck_forced_pwm   <= 1'b0;
    end
    else
    begin
      rail_started <= started_w;
      ldo3_millivolt_cs <= ldo_high_volts(
        ldo_three_settings_r[`VCODE_HI:`VCODE_LO]);
      ldo4_millivolt_cs <= ldo_low_volts(
        ldo_four_settings_r[`VCODE_HI:`VCODE_LO]);
      ldo5_millivolt_cs <= ldo_low_volts(
        ldo_five_settings_r[`VCODE_HI:`VCODE_LO]);
      buck_target_code <= control_r[`VSEL_BIT]
        ? buck_settings_first_r[`VCODE_HI:`VCODE_LO]
        : buck_settings_second_r[`VCODE_HI:`VCODE_LO];
      buck_forced_pwm <= buck_settings_second_r[`MODE_BIT];
    end
  end
endmodule // regulator_setting_registers

// file: tb/regulator_setting_registers_sva.sv
// checker for the regulator settings bank, sees only its top ports
// assumes one clock aclk and synchronous active-low aresetn
`timescale 1ns/1ps
module regulator_setting_registers_sva #(
  parameter STEP_CYCLES = 12800
)
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // enable and regulator controls
  input wire        hardware_enable_pin,
  input wire [3:0]  rail_started,
  input wire        buck_forced_pwm
);
  reg [31:0] rd_addr_r;
  reg [15:0] high_cnt_r;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_addr_r  <= 32'h0000_0000;
      high_cnt_r <= 16'h0000;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
        rd_addr_r <= s_axi_araddr;
      if (!hardware_enable_pin)
        high_cnt_r <= 16'h0000;
      else if (high_cnt_r != 16'hffff)
        high_cnt_r <= high_cnt_r + 16'h0001;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_second_read;
    s_axi_rvalid && s_axi_rresp == 2'b00 && rd_addr_r == 32'h0000_001c;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_busy_refuse: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property (s_axi_rvalid &&
    (rd_addr_r < 32'h0000_000c || rd_addr_r > 32'h0000_0020)
    |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_spare_zero: assert property (s_second_read
    |-> s_axi_rdata[7:6] == 2'b00)
    else $error("spare bits not zero");
  a_mode_readback: assert property (s_second_read
    |-> s_axi_rdata[5] == buck_forced_pwm)
    else $error("mode output differs from register");
  a_start_wait: assert property (
    (rail_started & ~$past(rail_started)) != 4'h0
    |-> high_cnt_r >= STEP_CYCLES)
    else $error("rail started before one delay step");
  a_start_bound: assert property (
    high_cnt_r >= 8 * STEP_CYCLES + 12 |-> rail_started == 4'hf)
    else $error("rail not started after longest delay");
  a_low_clears: assert property (
    !hardware_enable_pin [*8] |-> rail_started == 4'h0)
    else $error("rails still started with pin low");
endmodule // regulator_setting_registers_sva
bind regulator_setting_registers regulator_setting_registers_sva
  #(.STEP_CYCLES(STEP_CYCLES)) u_regulator_setting_registers_sva (.*);

// file: tb/axil_host.sv
// axi4-lite master standing in for the host processor
// assumes the bench watchdog ends any wait that never completes
`timescale 1ns/1ps
module axil_host
(
  // clock
  input  wire        aclk,
  // write side
  output reg  [31:0] s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  // read side
  output reg  [31:0] s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {96{1'b1}};
    s_axi_wstrb = 4'h0;
  end
  // idx is the register index, byte address is four times it
  task wr(input [7:0] idx, input [7:0] d, input [3:0] st, output [1:0] r);
    reg a, w, b;
    begin
      // at least one edge, so bready never drops and rises in one step
      repeat ($urandom_range(2, 1)) @(posedge aclk);
      s_axi_awaddr  <= 32'h0000_0004 * idx;
      s_axi_wdata   <= 32'h0000_0000 | d;
      s_axi_wstrb   <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      {a, w, b} = 3'b110;
      while (a || w)
      begin
        @(posedge aclk);
        if (a && s_axi_awready)
        begin
          a = 1'b0;
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr  <= ~s_axi_awaddr;
        end
        if (w && s_axi_wready)
        begin
          w = 1'b0;
          s_axi_wvalid <= 1'b0;
          s_axi_wdata  <= ~s_axi_wdata;
        end
      end
      while (!b)
      begin
        @(posedge aclk);
        b = s_axi_bvalid;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] idx, output [31:0] d, output [1:0] r);
    reg a;
    begin
      // let an edge pass so rready is not lowered and raised together
      @(posedge aclk);
      s_axi_araddr  <= 32'h0000_0004 * idx;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      a = 1'b0;
      while (!a)
      begin
        @(posedge aclk);
        a = s_axi_arready;
      end
      s_axi_arvalid <= 1'b0;
      s_axi_araddr  <= ~s_axi_araddr;
      a = 1'b0;
      while (!a)
      begin
        @(posedge aclk);
        a = s_axi_rvalid;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule // axil_host

// file: tb/test_regulator_setting_registers.sv
// self-checking bench for the regulator settings bank
// assumes the design runs with a 4-cycle delay step to keep runs short
`timescale 1ns/1ps
module test_regulator_setting_registers;
  localparam STEP = 4;
  logic aclk = 1'b0, aresetn, hardware_enable_pin;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, rail_started;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, buck_forced_pwm, s;
  logic [8:0]  ldo3_millivolt_cs, ldo4_millivolt_cs, ldo5_millivolt_cs;
  logic [4:0]  buck_target_code;
  logic [31:0] d, x;
  logic [7:0]  a, b, v;
  logic [2:0]  dl [4];
  int i, k, t, err_count, comparisons;
  int st [4];
  int rst [6] = '{8'h6c, 8'h9e, 8'hb1, 8'h09, 8'h07, 8'h00};
  int t3 [21] = '{175, 180, 185, 190, 200, 210, 220, 230, 240, 250, 260,
                  265, 270, 275, 280, 285, 290, 295, 300, 310, 330};
  int t45 [26] = '{125, 130, 135, 140, 145, 150, 155, 160, 165, 170, 175,
                   180, 185, 190, 200, 210, 220, 230, 240, 250, 260, 265,
                   270, 275, 280, 285};
  always #5 aclk = ~aclk;
  regulator_setting_registers #(.STEP_CYCLES(STEP))
    u_regulator_setting_registers (.*);
  axil_host u_axil_host (.*);
  ////////////////////////////////////////////////////////////////////////
  function int dec3(input [4:0] c);
    dec3 = (c < 11) ? 170 : t3[c - 11];
  endfunction
  function int dec45(input [4:0] c);
    dec45 = (c < 6) ? 120 : t45[c - 6];
  endfunction
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        err_count++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(32'h3188_9341));
    aresetn = 1'b0;
    hardware_enable_pin = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 6; i++)
    begin
      u_axil_host.rd(i + 3, d, r);
      cmp(d, rst[i]);
      cmp(r, 2'b00);
    end
    cmp(ldo3_millivolt_cs, 180);
    cmp(ldo4_millivolt_cs, 280);
    cmp(ldo5_millivolt_cs, 180);
    cmp(buck_target_code, 5'h07);
    cmp(buck_forced_pwm, 1'b0);
    // every voltage code through all three linear regulators
    for (i = 0; i < 32; i++)
    begin
      x = $urandom;
      v = {x[2:0], i[4:0]};
      for (k = 3; k < 6; k++)
        u_axil_host.wr(k, v, 4'hf, r);
      u_axil_host.rd(5, d, r);
      cmp(d, v);
      cmp(ldo3_millivolt_cs, dec3(i[4:0]));
      cmp(ldo4_millivolt_cs, dec45(i[4:0]));
      cmp(ldo5_millivolt_cs, dec45(i[4:0]));
    end
    for (i = 0; i < 10; i++)
    begin
      x = $urandom;
      {s, a, b} = {i[0], x[15:0]};
      if (i == 0)
        b = 8'hff;
      u_axil_host.wr(6, a, 4'hf, r);
      u_axil_host.wr(7, b, 4'hf, r);
      u_axil_host.wr(8, {7'h00, s}, 4'hf, r);
      u_axil_host.rd(7, d, r);
      cmp(d, b & 8'h3f);
      cmp(buck_forced_pwm, b[5]);
      cmp(buck_target_code, s ? a[4:0] : b[4:0]);
    end
    // a write with no byte lane set keeps the old value
    u_axil_host.wr(3, 8'h00, 4'h0, r);
    cmp(r, 2'b00);
    u_axil_host.rd(3, d, r);
    cmp(d, v);
    for (i = 0; i < 2; i++)
    begin
      u_axil_host.wr(i * 7 + 2, 8'h55, 4'hf, r);
      cmp(r, 2'b10);
      u_axil_host.rd(i * 7 + 2, d, r);
      cmp(r, 2'b10);
      cmp(d, 32'h0000_0000);
    end
    // start-up delays: boundary codes first, then random ones
    for (i = 0; i < 2; i++)
    begin
      x = $urandom;
      {dl[0], dl[1], dl[2], dl[3]} = i ? x[11:0] : {3'd0, 3'd7, 3'd3, 3'd5};
      for (k = 0; k < 4; k++)
      begin
        u_axil_host.wr(k + 3, {dl[k], 5'h0a}, 4'hf, r);
        st[k] = 0;
      end
      hardware_enable_pin <= 1'b1;
      for (t = 1; t <= 60; t++)
      begin
        @(posedge aclk);
        for (k = 0; k < 4; k++)
          if (rail_started[k] === 1'b1 && st[k] == 0)
            st[k] = t;
      end
      for (k = 0; k < 4; k++)
        cmp(st[k] >= (dl[k] + 1) * STEP + 2 &&
            st[k] <= (dl[k] + 1) * STEP + 9, 1);
      // control word shows all rails up and the last voltage select
      u_axil_host.rd(8, d, r);
      cmp(d, {27'h000_0000, 4'hf, s});
      cmp(r, 2'b00);
      hardware_enable_pin <= 1'b0;
      repeat (8) @(posedge aclk);
      cmp(rail_started, 4'h0);
    end
    end_of_test;
  end
endmodule // test_regulator_setting_registers
